// [logic/clkstop_defines.svh]
`ifndef CLKSTOP_DEFINES_SVH
`define CLKSTOP_DEFINES_SVH

// Register indices
`define IDX_REVISION_AND_MAKER 8'h04
`define IDX_PART_IDENTIFIER    8'h05
`define IDX_BLOCK_READ_LENGTH  8'h06

// Field positions inside the identification byte
`define REV_FIELD_MSB   7
`define REV_FIELD_LSB   4
`define MAKER_FIELD_MSB 3
`define MAKER_FIELD_LSB 0

// Reset values
`define RST_BLOCK_READ_LENGTH 8'h07

// Qualification and resume counts, in edges of the complementary output
`define QUAL_EDGES     2'd2
`define RESUME_PERIODS 3'd2

// Timing
`define SYS_CLOCK_MHZ  20
`define LOCK_TIME_US   1000
`define LOCK_CYCLES    (`LOCK_TIME_US * `SYS_CLOCK_MHZ)

`endif

// [logic/clkstop_pkg.sv]
package clkstop_pkg;

  // Power state of the output stage
  typedef enum logic [1:0] {
    PWR_RUN    = 2'b00,
    PWR_PARKED = 2'b01,
    PWR_OFF    = 2'b10,
    PWR_WAKE   = 2'b11
  } pwr_state_t;

endpackage

// [logic/diff_clock_stop_powerdown_ctrl.sv]
// How it works
// - Read-only revision and maker byte, index four
// - Read-only eight-bit part identifier at index five
// - Read-write block read length, resets to seven
// - Power-down pin async, active low, stops clocks
// - Park outputs before the PLL is disabled
// - Two low samples, then park at next fall
// - Driven park: true high, double current, complement off
// - Tri-state park: both outputs undriven
// - Clocks locked within one millisecond of release
// - Tri-state mode: drive high soon after release
// - Halt pin async, active low, clean stop/start
// - Halt level stable two edges to count
// - Stoppable outputs halt after next transition
// - Driven stop: true high, complement undriven
// - Tri-state stop: both outputs undriven
// - Resume together, glitch-free, two to six periods
// - Tri-state stop: drive high at release
// - Stop park style from control byte bit six
`include "clkstop_defines.svh"

module diff_clock_stop_powerdown_ctrl
  import clkstop_pkg::*;
#(
  parameter int         PAIRS       = 8,
  parameter int         LOCK_CYCLES = `LOCK_CYCLES,
  // Arbitrary identification values
  parameter logic [3:0] REVISION_ID = 4'h2,
  parameter logic [3:0] MAKER_ID    = 4'h6,
  parameter logic [7:0] PART_ID     = 8'h5a
) (
  // System clock and reset
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  // Output clock domain
  input  wire logic             out_clk_i,
  // Register byte port
  input  wire logic [7:0]       reg_index_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_write_i,
  input  wire logic             reg_read_i,
  output logic      [7:0]       reg_rdata_o,
  output logic      [7:0]       block_read_length_o,
  // Control byte fields kept elsewhere
  input  wire logic             powerdown_park_select_i,
  input  wire logic             halt_park_select_i,
  input  wire logic [PAIRS-1:0] output_enable_i,
  input  wire logic [PAIRS-1:0] output_stoppable_i,
  // Control pins
  input  wire logic             power_down_n_i,
  input  wire logic             output_halt_n_i,
  // Output pairs and PLL
  output logic [PAIRS-1:0]      clk_out_true_o,
  output logic [PAIRS-1:0]      clk_out_true_oe_o,
  output logic [PAIRS-1:0]      clk_out_true_boost_o,
  output logic [PAIRS-1:0]      clk_out_comp_o,
  output logic [PAIRS-1:0]      clk_out_comp_oe_o,
  output logic                  pll_enable_o
);

  // ---------------- System clock domain ----------------
  logic [7:0]  read_length_r, read_length_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic [31:0] lock_cnt_r, lock_cnt_nxt;
  logic        locked_r, locked_nxt;
  logic        pllen_s1_r, pllen_s2_r;

  function automatic logic [7:0] reg_value(input logic [7:0] idx, input logic [7:0] len);
    unique case (idx)
      `IDX_REVISION_AND_MAKER: reg_value = {REVISION_ID, MAKER_ID};
      `IDX_PART_IDENTIFIER:    reg_value = PART_ID;
      `IDX_BLOCK_READ_LENGTH:  reg_value = len;
      default:                 reg_value = 8'h00;
    endcase
  endfunction

  always_comb begin
    read_length_nxt = read_length_r;
    rdata_nxt       = rdata_r;
    if (reg_write_i && reg_index_i == `IDX_BLOCK_READ_LENGTH) begin
      read_length_nxt = reg_wdata_i;
    end
    if (reg_read_i) begin
      rdata_nxt = reg_value(reg_index_i, read_length_r);
    end
    // Lock timer, restarted whenever the PLL is off
    lock_cnt_nxt = lock_cnt_r;
    locked_nxt   = locked_r;
    if (!pllen_s2_r) begin
      lock_cnt_nxt = 32'h0;
      locked_nxt   = 1'b0;
    end else if (!locked_r) begin
      if (lock_cnt_r >= 32'(LOCK_CYCLES - 1)) begin
        locked_nxt = 1'b1;
      end else begin
        lock_cnt_nxt = lock_cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      read_length_r <= `RST_BLOCK_READ_LENGTH;
      rdata_r       <= 8'h00;
      lock_cnt_r    <= 32'h0;
      locked_r      <= 1'b0;
      pllen_s1_r    <= 1'b0;
      pllen_s2_r    <= 1'b0;
    end else begin
      read_length_r <= read_length_nxt;
      rdata_r       <= rdata_nxt;
      lock_cnt_r    <= lock_cnt_nxt;
      locked_r      <= locked_nxt;
      pllen_s1_r    <= pll_enable_o;
      pllen_s2_r    <= pllen_s1_r;
    end
  end

  assign reg_rdata_o         = rdata_r;
  assign block_read_length_o = read_length_r;

  // ---------------- Output clock domain ----------------
  // Local reset: asserts at once, releases on the output clock
  logic lrst_a_r, lrst_n_r;

  always_ff @(posedge out_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lrst_a_r <= 1'b0;
      lrst_n_r <= 1'b0;
    end else begin
      lrst_a_r <= 1'b1;
      lrst_n_r <= lrst_a_r;
    end
  end

  // Synchronisers; mode and mask inputs are quasi-static
  logic             pd_s1_r, pd_s2_r, halt_s1_r, halt_s2_r;
  logic             lock_s1_r, lock_s2_r;
  logic             pdsel_s1_r, pdsel_s2_r, hsel_s1_r, hsel_s2_r;
  logic [PAIRS-1:0] en_s1_r, en_s2_r, stp_s1_r, stp_s2_r;

  always_ff @(posedge out_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      {pd_s1_r, pd_s2_r, halt_s1_r, halt_s2_r} <= 4'hf;
      {lock_s1_r, lock_s2_r, pdsel_s1_r, pdsel_s2_r, hsel_s1_r, hsel_s2_r} <= 6'h00;
      {en_s1_r, en_s2_r, stp_s1_r, stp_s2_r} <= {(4*PAIRS){1'b0}};
    end else begin
      {pd_s2_r, pd_s1_r}       <= {pd_s1_r, power_down_n_i};
      {halt_s2_r, halt_s1_r}   <= {halt_s1_r, output_halt_n_i};
      {lock_s2_r, lock_s1_r}   <= {lock_s1_r, locked_r};
      {pdsel_s2_r, pdsel_s1_r} <= {pdsel_s1_r, powerdown_park_select_i};
      {hsel_s2_r, hsel_s1_r}   <= {hsel_s1_r, halt_park_select_i};
      {en_s2_r, en_s1_r}       <= {en_s1_r, output_enable_i};
      {stp_s2_r, stp_s1_r}     <= {stp_s1_r, output_stoppable_i};
    end
  end

  // Core state
  pwr_state_t       pwr_r, pwr_nxt;
  logic             phase_r, phase_nxt;
  logic [1:0]       pd_lows_r, pd_lows_nxt;
  logic             halt_prev_r, halt_prev_nxt;
  logic             halt_q_r, halt_q_nxt;
  logic [PAIRS-1:0] stopped_r, stopped_nxt;
  logic [2:0]       resume_cnt_r, resume_cnt_nxt;
  logic             pll_r, pll_nxt;
  logic             comp_rise, true_rise;

  // Complement rises when the true phase falls
  assign comp_rise = (pwr_r == PWR_RUN) && phase_r;
  assign true_rise = (pwr_r == PWR_RUN) && !phase_r;

  always_comb begin
    pwr_nxt        = pwr_r;
    phase_nxt      = phase_r;
    pd_lows_nxt    = pd_lows_r;
    halt_prev_nxt  = halt_prev_r;
    halt_q_nxt     = halt_q_r;
    stopped_nxt    = stopped_r;
    resume_cnt_nxt = resume_cnt_r;
    pll_nxt        = pll_r;
    if (pwr_r == PWR_RUN) begin
      phase_nxt = !phase_r;
    end
    // Count consecutive low samples of power-down
    if (comp_rise) begin
      if (pd_s2_r) begin
        pd_lows_nxt = 2'd0;
      end else if (pd_lows_r != `QUAL_EDGES) begin
        pd_lows_nxt = pd_lows_r + 2'd1;
      end
      // Level must match on two consecutive edges
      halt_prev_nxt = halt_s2_r;
      if (halt_s2_r == halt_prev_r) begin
        halt_q_nxt = halt_s2_r;
      end
    end
    // Stoppable outputs freeze once the true side is high
    if (true_rise && !halt_q_r) begin
      stopped_nxt = stopped_r | stp_s2_r;
      resume_cnt_nxt = 3'd0;
    end
    // All stopped outputs resume on one common edge
    if (halt_q_r && stopped_r != '0 && comp_rise) begin
      if (resume_cnt_r >= `RESUME_PERIODS - 3'd1) begin
        stopped_nxt    = '0;
        resume_cnt_nxt = 3'd0;
      end else begin
        resume_cnt_nxt = resume_cnt_r + 3'd1;
      end
    end
    unique case (pwr_r)
      PWR_RUN: begin
        // Park on the complement's next fall
        if (pd_lows_r == `QUAL_EDGES && !phase_r) begin
          pwr_nxt   = PWR_PARKED;
          phase_nxt = 1'b1;
        end
      end
      PWR_PARKED: begin
        // PLL goes off only after the outputs are parked
        pll_nxt = 1'b0;
        pwr_nxt = PWR_OFF;
      end
      PWR_OFF: begin
        // Release powers up once old lock clears
        if (pd_s2_r && !lock_s2_r) begin
          pll_nxt = 1'b1;
          pwr_nxt = PWR_WAKE;
        end
      end
      PWR_WAKE: begin
        // Resume only with a locked PLL
        if (lock_s2_r) begin
          pwr_nxt     = PWR_RUN;
          phase_nxt   = 1'b1;
          pd_lows_nxt = 2'd0;
        end
      end
    endcase
  end

  always_ff @(posedge out_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      pwr_r        <= PWR_WAKE;
      phase_r      <= 1'b1;
      pd_lows_r    <= 2'd0;
      halt_prev_r  <= 1'b1;
      halt_q_r     <= 1'b1;
      stopped_r    <= '0;
      resume_cnt_r <= 3'd0;
      pll_r        <= 1'b1;
    end else begin
      pwr_r        <= pwr_nxt;
      phase_r      <= phase_nxt;
      pd_lows_r    <= pd_lows_nxt;
      halt_prev_r  <= halt_prev_nxt;
      halt_q_r     <= halt_q_nxt;
      stopped_r    <= stopped_nxt;
      resume_cnt_r <= resume_cnt_nxt;
      pll_r        <= pll_nxt;
    end
  end

  // Pin drive, computed from next state so pins move with it
  logic [PAIRS-1:0] t_nxt, toe_nxt, tb_nxt, c_nxt, coe_nxt;
  logic [PAIRS-1:0] t_r, toe_r, tb_r, c_r, coe_r;

  generate
    for (genvar i = 0; i < PAIRS; i++) begin : g_pair
      always_comb begin
        t_nxt[i]   = phase_nxt;
        toe_nxt[i] = 1'b1;
        tb_nxt[i]  = 1'b0;
        c_nxt[i]   = !phase_nxt;
        coe_nxt[i] = 1'b1;
        if (pwr_nxt == PWR_WAKE) begin
          // Pull the true side high at once after release
          t_nxt[i]   = 1'b1;
          toe_nxt[i] = en_s2_r[i];
          tb_nxt[i]  = 1'b1;
          c_nxt[i]   = 1'b0;
          coe_nxt[i] = 1'b0;
        end else if (pwr_nxt != PWR_RUN) begin
          t_nxt[i]   = 1'b1;
          toe_nxt[i] = !pdsel_s2_r && en_s2_r[i];
          tb_nxt[i]  = 1'b1;
          c_nxt[i]   = 1'b0;
          // Tri-state park leaves both sides free
          coe_nxt[i] = 1'b0;
        end else if (!en_s2_r[i]) begin
          toe_nxt[i] = 1'b0;
          coe_nxt[i] = 1'b0;
        end else if (stopped_nxt[i]) begin
          t_nxt[i]   = 1'b1;
          c_nxt[i]   = 1'b0;
          coe_nxt[i] = 1'b0;
          // In tri-state style, undriven until the release is qualified
          toe_nxt[i] = !hsel_s2_r || halt_q_nxt;
        end
      end
    end
  endgenerate

  always_ff @(posedge out_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      t_r   <= '0;
      toe_r <= '0;
      tb_r  <= '0;
      c_r   <= '0;
      coe_r <= '0;
    end else begin
      t_r   <= t_nxt;
      toe_r <= toe_nxt;
      tb_r  <= tb_nxt;
      c_r   <= c_nxt;
      coe_r <= coe_nxt;
    end
  end

  // Halt stops and restarts through the gated pin drive
  assign clk_out_true_o       = t_r;
  assign clk_out_true_oe_o    = toe_r;
  assign clk_out_true_boost_o = tb_r;
  assign clk_out_comp_o       = c_r;
  assign clk_out_comp_oe_o    = coe_r;
  assign pll_enable_o         = pll_r;
endmodule

// [testbench/clkstop_checker_assertions.sv]
module clkstop_checker #(
  parameter int PAIRS = 8
) (
  // Clocks and reset
  input wire logic             clock_i,
  input wire logic             resetn_i,
  input wire logic             out_clk_i,
  // Register port
  input wire logic [7:0]       reg_index_i,
  input wire logic [7:0]       reg_wdata_i,
  input wire logic             reg_write_i,
  input wire logic             reg_read_i,
  input wire logic [7:0]       reg_rdata_o,
  input wire logic [7:0]       block_read_length_o,
  // Output stage
  input wire logic             powerdown_park_select_i,
  input wire logic [PAIRS-1:0] output_enable_i,
  input wire logic [PAIRS-1:0] clk_out_true_o,
  input wire logic [PAIRS-1:0] clk_out_true_oe_o,
  input wire logic [PAIRS-1:0] clk_out_comp_oe_o,
  input wire logic             pll_enable_o
);
  timeunit 1ns;
  timeprecision 100ps;

  chk_len_write: assert property (@(posedge clock_i) disable iff (!resetn_i)
    reg_write_i && reg_index_i == 8'h06 |=> block_read_length_o == $past(reg_wdata_i))
    else $error("length write lost");
  chk_ro_ignored: assert property (@(posedge clock_i) disable iff (!resetn_i)
    reg_write_i && reg_index_i != 8'h06 |=> $stable(block_read_length_o))
    else $error("stray write changed length");
  chk_len_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
    reg_read_i && !reg_write_i && reg_index_i == 8'h06 |=>
    reg_rdata_o == $past(block_read_length_o))
    else $error("length read wrong");
  chk_unmapped_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
    reg_read_i && (reg_index_i < 8'h04 || reg_index_i > 8'h06) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !reg_read_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  chk_park_comp: assert property (@(posedge out_clk_i) disable iff (!resetn_i)
    !pll_enable_o |-> clk_out_comp_oe_o == '0)
    else $error("complement driven while off");
  chk_park_first: assert property (@(posedge out_clk_i) disable iff (!resetn_i)
    $fell(pll_enable_o) |-> $past(clk_out_comp_oe_o) == '0)
    else $error("pll off before park");
  chk_tri_park: assert property (@(posedge out_clk_i) disable iff (!resetn_i)
    !pll_enable_o && powerdown_park_select_i |-> clk_out_true_oe_o == '0)
    else $error("true driven in tri park");
  chk_drv_park: assert property (@(posedge out_clk_i) disable iff (!resetn_i)
    !pll_enable_o && !powerdown_park_select_i |->
    clk_out_true_oe_o == output_enable_i && (clk_out_true_o & output_enable_i) == output_enable_i)
    else $error("driven park wrong");

  cover property (@(posedge clock_i) reg_write_i && reg_index_i == 8'h06);
  cover property (@(posedge clock_i) reg_read_i && reg_index_i == 8'h07);
  cover property (@(posedge out_clk_i) $fell(pll_enable_o));
endmodule

// [testbench/diff_clock_stop_powerdown_ctrl_tb.sv]
module diff_clock_stop_powerdown_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       run = 1'b1;
  logic       out_clk_i;
  logic [7:0] reg_index_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_write_i = 1'b0;
  logic       reg_read_i = 1'b0;
  logic       pd_sel = 1'b0;
  logic       halt_sel = 1'b0;
  logic [7:0] enable = 8'hff;
  logic [7:0] stoppable = 8'h0f;
  logic       pd_n = 1'b1;
  logic       halt_n = 1'b1;
  logic [7:0] rdata, len, t_o, t_oe, boost, c_o, c_oe;
  logic       pll_en;
  int         failures = 0;
  int         check_count = 0;

  always #25 clock_i = ~clock_i;
  ref_clock_source ref_clock_source_i (.run_i(run), .out_clk_o(out_clk_i));
  diff_clock_stop_powerdown_ctrl #(.LOCK_CYCLES(20), .REVISION_ID(4'h3), .MAKER_ID(4'h9),
    .PART_ID(8'h4c)) diff_clock_stop_powerdown_ctrl_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .out_clk_i(out_clk_i), .reg_index_i(reg_index_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(rdata),
    .block_read_length_o(len), .powerdown_park_select_i(pd_sel), .halt_park_select_i(halt_sel),
    .output_enable_i(enable), .output_stoppable_i(stoppable), .power_down_n_i(pd_n),
    .output_halt_n_i(halt_n), .clk_out_true_o(t_o), .clk_out_true_oe_o(t_oe),
    .clk_out_true_boost_o(boost), .clk_out_comp_o(c_o), .clk_out_comp_oe_o(c_oe),
    .pll_enable_o(pll_en));

  task final_report;
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clock_i);
    reg_index_i <= idx;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask
  task rdc(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge clock_i);
    reg_index_i <= idx;
    reg_read_i <= 1'b1;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    @(negedge clock_i);
    check(rdata, exp);
  endtask
  task oc(input int n);
    repeat (n) @(negedge out_clk_i);
  endtask
  // Halt in one park style, then resume timing
  task halt_run(input logic m);
    int n;
    logic [7:0] t;
    @(posedge clock_i);
    halt_sel <= m;
    halt_n <= 1'b0;
    oc(24);
    t = t_o;
    oc(1);
    check({t[3:0], t_o[3:0]}, 8'hff);
    check({4'h0, t[7:4] ^ t_o[7:4]}, 8'h0f);
    check({4'h0, c_o[7:4] ^ t_o[7:4]}, 8'h0f);
    check({4'h0, c_oe[3:0]}, 8'h00);
    check({4'h0, c_o[3:0]}, 8'h00);
    check({4'h0, boost[3:0]}, 8'h00);
    check({4'h0, t_oe[3:0]}, {4'h0, {4{!m}}});
    @(posedge clock_i);
    halt_n <= 1'b1;
    n = 0;
    do begin
      oc(1);
      n++;
    end while (t_o[0] && n < 40);
    check({7'h0, n >= 4 && n <= 13}, 8'h01);
    check({4'h0, t_o[3:0]}, 8'h00);
    check({4'h0, t_oe[3:0]}, 8'h0f);
  endtask
  // Power-down in one park style, clock removal, wake
  task pd_run(input logic m);
    int n;
    @(posedge clock_i);
    pd_sel <= m;
    enable <= 8'h7f;
    pd_n <= 1'b0;
    n = 0;
    while (pll_en && n < 40) begin
      oc(1);
      n++;
    end
    check({7'h0, n >= 4 && n < 40}, 8'h01);
    check(c_oe, 8'h00);
    check(t_oe, m ? 8'h00 : 8'h7f);
    check(t_o & boost & t_oe, m ? 8'h00 : 8'h7f);
    run = 1'b0;
    repeat (40) @(posedge clock_i);
    run = 1'b1;
    oc(4);
    @(posedge clock_i);
    pd_n <= 1'b1;
    n = 0;
    do begin
      oc(1);
      n++;
    end while (t_oe[0] !== 1'b1 && n < 20);
    check(t_o & t_oe, 8'h7f);
    n = 0;
    while (t_o[0] && n < 200) begin
      oc(1);
      n++;
    end
    check({7'h0, n < 200}, 8'h01);
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    check(len, 8'h07);
    rdc(8'h04, 8'h39);
    rdc(8'h05, 8'h4c);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h09, 8'h00);
    rdc(8'h04, 8'h39);
    rdc(8'h05, 8'h4c);
    rdc(8'h06, 8'h07);
    wr(8'h06, 8'hff);
    rdc(8'h06, 8'hff);
    wr(8'h06, 8'h00);
    rdc(8'h06, 8'h00);
    rdc(8'h07, 8'h00);
    oc(40);
    halt_run(1'b0);
    halt_run(1'b1);
    @(posedge clock_i);
    halt_n <= 1'b0;
    @(posedge clock_i);
    halt_n <= 1'b1;
    oc(12);
    t_o_probe();
    pd_run(1'b0);
    pd_run(1'b1);
    final_report();
  end
  task t_o_probe;
    logic t;
    t = t_o[0];
    oc(1);
    check({7'h0, t ^ t_o[0]}, 8'h01);
  endtask

  // Whole run needs well under a millisecond
  initial begin
    #1000000;
    failures++;
    final_report();
  end
endmodule

bind diff_clock_stop_powerdown_ctrl clkstop_checker #(.PAIRS(PAIRS)) clkstop_checker_i (
  .clock_i(clock_i), .resetn_i(resetn_i), .out_clk_i(out_clk_i), .reg_index_i(reg_index_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .block_read_length_o(block_read_length_o),
  .powerdown_park_select_i(powerdown_park_select_i), .output_enable_i(output_enable_i),
  .clk_out_true_o(clk_out_true_o), .clk_out_true_oe_o(clk_out_true_oe_o),
  .clk_out_comp_oe_o(clk_out_comp_oe_o), .pll_enable_o(pll_enable_o));

// [testbench/ref_clock_source.sv]
module ref_clock_source (
  // Run request and clock
  input  wire logic run_i,
  output logic      out_clk_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Runs whenever halt is used, stops only under power-down
  initial begin
    out_clk_o = 1'b0;
    #7;
    forever #16 out_clk_o = run_i ? ~out_clk_o : 1'b0;
  end
endmodule
